// ---- art_clock_select.sv ----
// count clock source: prescaler taps and falling-edge sampled event input
`timescale 1ns/10ps
module art_clock_select
	import art_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [2:0]  clk_sel,
	input  wire logic        event_input,
	output logic             count_tick
);

	logic [PRESC_W-1:0]  presc_q;
	logic [PRESC_W-1:0]  presc_d;
	logic                ev_fall_q;
	logic                ev_last_q;
	logic                ev_last_d;
	logic                ev_rise;
	logic [TAP_COUNT-1:0] tap_hit;

	// free-running base prescaler
	always_comb begin
		presc_d   = presc_q + 1'b1;
		ev_last_d = ev_fall_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q   <= '0;
			ev_last_q <= 1'b0;
		end else begin
			presc_q   <= presc_d;
			ev_last_q <= ev_last_d;
		end
	end

	// event pin sampled on the falling clock edge
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_fall_q <= 1'b0;
		end else begin
			ev_fall_q <= event_input;
		end
	end

	// one pulse per sampled rising edge; pulses under one clock may be lost
	assign ev_rise = ev_fall_q & ~ev_last_q;

	// one tap per prescale ratio
	genvar i;
	generate
		for (i = 0; i < TAP_COUNT; i++) begin : g_tap
			assign tap_hit[i] = ((presc_q & TAP_MASK[i]) == TAP_MASK[i]);
		end
	endgenerate

	assign count_tick = (clk_sel == SEL_EVENT) ? ev_rise : tap_hit[clk_sel];

endmodule

// ---- art_event_src.sv ----
// external event source and timer output pin load
`timescale 1ns/10ps
module art_event_src (
	input  wire logic pclk,
	output logic      event_input,
	input  wire logic timer_out
);
	// idle level of the event pin is low
	initial begin
		event_input = 1'b0;
	end

	// level seen by the load on the timer output pin
	logic load_level;
	always @(posedge pclk) begin
		load_level <= timer_out;
	end

	// one high pulse of width clocks, then an equal low gap
	task automatic pulse(input int unsigned width);
		event_input <= 1'b1;
		repeat (width) @(posedge pclk);
		event_input <= 1'b0;
		repeat (width) @(posedge pclk);
	endtask
endmodule

// ---- art_pkg.sv ----
// constants and types shared by the auto-reload timer files
package art_pkg;

	// apb geometry
	localparam int unsigned   ADDR_W          = 12;
	localparam int unsigned   DATA_W          = 32;

	// register byte addresses
	localparam logic [11:0]   ADDR_COUNT      = 12'h000;
	localparam logic [11:0]   ADDR_RELOAD     = 12'h004;
	localparam logic [11:0]   ADDR_CONTROL    = 12'h008;
	localparam logic [11:0]   ADDR_STATUS     = 12'h00c;
	localparam logic [11:0]   ADDR_MASK       = 12'h010;
	localparam logic [11:0]   ADDR_PRIORITY   = 12'h014;

	// timer_control field layout
	localparam int unsigned   CTRL_SEL_LSB    = 0;
	localparam int unsigned   CTRL_SEL_MSB    = 2;
	localparam int unsigned   CTRL_RUN_BIT    = 3;
	localparam int unsigned   CTRL_OUT_BIT    = 7;
	localparam logic [7:0]    CTRL_FIXED_ONES = 8'h70;
	localparam logic [7:0]    CTRL_RESET      = 8'h70;

	// reset values of the timer data registers (undefined on the part), and the counter top value ffh
	localparam logic [7:0]    COUNT_RESET     = 8'h00;
	localparam logic [7:0]    RELOAD_RESET    = 8'h00;
	localparam logic [7:0]    COUNT_TOP       = 8'hff;

	// interrupt side fields
	localparam int unsigned   FLAG_OVF_BIT    = 0;
	localparam int unsigned   PRIO_LOW_BIT    = 0;
	localparam int unsigned   PRIO_HIGH_BIT   = 1;
	localparam logic [15:0]   OVF_VECTOR      = 16'h0072;
	localparam logic [1:0]    PRIO_LEVEL0     = 2'h0;
	localparam logic [1:0]    PRIO_LEVEL1     = 2'h1;
	localparam logic [1:0]    PRIO_LEVEL2     = 2'h2;

	// count clock select: codes 0..6 are prescaler taps, 7 is the event input
	localparam int unsigned   PRESC_W         = 6;
	localparam int unsigned   TAP_COUNT       = 7;
	localparam logic [2:0]    SEL_EVENT       = 3'h7;
	localparam logic [5:0]    TAP_MASK [0:6]  = '{6'h00, 6'h01, 6'h03, 6'h07,
	                                             6'h0f, 6'h1f, 6'h3f};

	// register decode result, one-hot
	typedef enum logic [6:0] {
		REG_COUNT    = 7'h01,
		REG_RELOAD   = 7'h02,
		REG_CONTROL  = 7'h04,
		REG_STATUS   = 7'h08,
		REG_MASK     = 7'h10,
		REG_PRIORITY = 7'h20,
		REG_NONE     = 7'h40
	} art_reg_type;

endpackage

// ---- art_timer.sv ----
// 8-bit auto-reload timer with toggle output, apb slave and interrupt
`timescale 1ns/10ps
module art_timer
	import art_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [DATA_W-1:0]  pwdata,
	output logic      [DATA_W-1:0]  prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               event_input,
	output logic                    timer_out,
	output logic                    pwm_clock,
	output logic                    irq,
	output logic      [1:0]         irq_priority,
	output logic      [15:0]        irq_vector
);

	// register state
	logic [7:0]         count_q;
	logic [7:0]         count_d;
	logic [7:0]         reload_q;
	logic [7:0]         reload_d;
	logic [7:0]         ctrl_q;
	logic [7:0]         ctrl_d;
	logic               flag_q;
	logic               flag_d;
	logic               enable_q;
	logic               enable_d;
	logic [1:0]         prio_q;
	logic [1:0]         prio_d;
	logic               pwm_q;
	logic               pwm_d;
	logic [DATA_W-1:0]  rdata_q;
	logic [DATA_W-1:0]  rdata_d;
	logic               err_q;
	logic               err_d;

	// decode and timing
	art_reg_type        reg_hit;
	logic               setup_phase;
	logic               wr_access;
	logic               count_wr;
	logic               reload_wr;
	logic               ctrl_wr;
	logic               flag_wr;
	logic               enable_wr;
	logic               prio_wr;
	logic               count_tick;
	logic               run;
	logic               step;
	logic               overflow;
	logic [7:0]         read_value;

	// address to register, used by both read and write paths
	function automatic art_reg_type decode_reg(input logic [ADDR_W-1:0] addr);
		art_reg_type r;
		r = REG_NONE;
		case (addr)
			ADDR_COUNT:    r = REG_COUNT;
			ADDR_RELOAD:   r = REG_RELOAD;
			ADDR_CONTROL:  r = REG_CONTROL;
			ADDR_STATUS:   r = REG_STATUS;
			ADDR_MASK:     r = REG_MASK;
			ADDR_PRIORITY: r = REG_PRIORITY;
			default:       r = REG_NONE;
		endcase
		return r;
	endfunction

	// count clock source
	art_clock_select u_clock_select (
		.pclk        (pclk),
		.presetn     (presetn),
		.clk_sel     (ctrl_q[CTRL_SEL_MSB:CTRL_SEL_LSB]),
		.event_input (event_input),
		.count_tick  (count_tick)
	);

	// bus phase and write strobes
	assign reg_hit     = decode_reg(paddr);
	assign setup_phase = psel & ~penable;
	assign wr_access   = psel & penable & pwrite;
	assign count_wr    = wr_access & (reg_hit == REG_COUNT);
	assign reload_wr   = wr_access & (reg_hit == REG_RELOAD);
	assign ctrl_wr     = wr_access & (reg_hit == REG_CONTROL);
	assign flag_wr     = wr_access & (reg_hit == REG_STATUS);
	assign enable_wr   = wr_access & (reg_hit == REG_MASK);
	assign prio_wr     = wr_access & (reg_hit == REG_PRIORITY);

	// counting step and overflow detection
	assign run      = ctrl_q[CTRL_RUN_BIT];
	assign step     = run & count_tick;
	assign overflow = step & (count_q == COUNT_TOP);

	// read mux of the selected register
	always_comb begin
		case (reg_hit)
			REG_COUNT:    read_value = count_q;
			REG_RELOAD:   read_value = reload_q;
			REG_CONTROL:  read_value = ctrl_q | CTRL_FIXED_ONES;
			REG_STATUS:   read_value = {7'h00, flag_q};
			REG_MASK:     read_value = {7'h00, enable_q};
			REG_PRIORITY: read_value = {6'h00, prio_q};
			default:      read_value = 8'h00;
		endcase
	end

	// counter and reload register
	always_comb begin
		count_d  = count_q;
		reload_d = reload_q;
		if (step) begin
			if (overflow) begin
				count_d = reload_q;
			end else begin
				count_d = count_q + 8'h01;
			end
		end
		if (reload_wr) begin
			reload_d = pwdata[7:0];
		end
		// a counter write wins over counting and mirrors into reload
		if (count_wr) begin
			count_d  = pwdata[7:0];
			reload_d = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q  <= COUNT_RESET;
			reload_q <= RELOAD_RESET;
		end else begin
			count_q  <= count_d;
			reload_q <= reload_d;
		end
	end

	// control register: fixed ones, output level toggle
	always_comb begin
		ctrl_d = ctrl_q;
		if (overflow) begin
			ctrl_d[CTRL_OUT_BIT] = ~ctrl_q[CTRL_OUT_BIT];
		end
		// a write in the overflow cycle wins, so the toggle is lost then
		if (ctrl_wr) begin
			ctrl_d = pwdata[7:0] | CTRL_FIXED_ONES;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// interrupt flag, enable and priority
	always_comb begin
		flag_d   = flag_q;
		enable_d = enable_q;
		prio_d   = prio_q;
		if (flag_wr && pwdata[FLAG_OVF_BIT]) begin
			flag_d = 1'b0;
		end
		// set after clear so a same-cycle overflow is kept
		if (overflow) begin
			flag_d = 1'b1;
		end
		if (enable_wr) begin
			enable_d = pwdata[FLAG_OVF_BIT];
		end
		if (prio_wr) begin
			prio_d = pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q   <= 1'b0;
			enable_q <= 1'b0;
			prio_q   <= 2'h0;
		end else begin
			flag_q   <= flag_d;
			enable_q <= enable_d;
			prio_q   <= prio_d;
		end
	end

	// pwm time base pulse and apb read data
	always_comb begin
		pwm_d   = overflow;
		rdata_d = rdata_q;
		err_d   = err_q;
		if (setup_phase) begin
			rdata_d = {24'h000000, read_value};
			err_d   = (reg_hit == REG_NONE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_q   <= 1'b0;
			rdata_q <= '0;
			err_q   <= 1'b0;
		end else begin
			pwm_q   <= pwm_d;
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	// outputs
	assign prdata     = rdata_q;
	assign pready     = 1'b1;
	assign pslverr    = err_q & psel & penable;
	assign timer_out  = ctrl_q[CTRL_OUT_BIT];
	assign pwm_clock  = pwm_q;
	assign irq        = flag_q & enable_q;
	assign irq_vector = OVF_VECTOR;

	// three priority levels from two flags
	always_comb begin
		if (prio_q[PRIO_HIGH_BIT]) begin
			irq_priority = PRIO_LEVEL2;
		end else if (prio_q[PRIO_LOW_BIT]) begin
			irq_priority = PRIO_LEVEL1;
		end else begin
			irq_priority = PRIO_LEVEL0;
		end
	end

	// checks
	sequence s_ovf_no_write;
		overflow && !count_wr;
	endsequence

	sequence s_apb_write_count;
		psel && !penable && pwrite && (reg_hit == REG_COUNT) ##1 count_wr;
	endsequence

	property p_reload_on_ovf;
		@(posedge pclk) disable iff (!presetn)
		s_ovf_no_write |=> (count_q == $past(reload_q));
	endproperty
	a_reload_on_ovf: assert property (p_reload_on_ovf)
		else $error("counter not reloaded on overflow");

	property p_count_step;
		@(posedge pclk) disable iff (!presetn)
		(step && (count_q != COUNT_TOP) && !count_wr) |=> (count_q == $past(count_q) + 8'h01);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not step by one");

	property p_halt;
		@(posedge pclk) disable iff (!presetn)
		(!run && !count_wr) |=> $stable(count_q);
	endproperty
	a_halt: assert property (p_halt)
		else $error("counter moved while halted");

	property p_write_mirror;
		@(posedge pclk) disable iff (!presetn)
		s_apb_write_count |=> (count_q == $past(pwdata[7:0])) && (reload_q == count_q);
	endproperty
	a_write_mirror: assert property (p_write_mirror)
		else $error("counter write not mirrored into reload");

	property p_fixed_bits;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && (reg_hit == REG_CONTROL)) |=> (prdata[6:4] == 3'h7);
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("control bits 4 to 6 did not read as one");

	property p_toggle;
		@(posedge pclk) disable iff (!presetn)
		(overflow && !ctrl_wr) |=> (timer_out != $past(timer_out)) ##1 1'b1;
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("output level not inverted on overflow");

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		overflow |=> flag_q && pwm_clock;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("overflow did not set flag and pwm pulse");

	property p_irq_gate;
		@(posedge pclk) disable iff (!presetn)
		(enable_wr && !pwdata[FLAG_OVF_BIT]) |=> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt raised while disabled");

	property p_irq_follow;
		@(posedge pclk) disable iff (!presetn)
		(overflow && enable_q && !enable_wr) |=> irq;
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("enabled overflow did not raise interrupt");

	property p_ctrl_write;
		@(posedge pclk) disable iff (!presetn)
		ctrl_wr |=> (ctrl_q == ($past(pwdata[7:0]) | CTRL_FIXED_ONES));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write did not keep bits 4 to 6 at one");

	property p_pwm_pulse;
		@(posedge pclk) disable iff (!presetn)
		!overflow |=> !pwm_clock;
	endproperty
	a_pwm_pulse: assert property (p_pwm_pulse)
		else $error("pwm clock high without overflow");

endmodule

// ---- art_timer_tb.sv ----
// self-checking bench for the auto-reload timer
`timescale 1ns/10ps
module art_timer_tb
	import art_pkg::*;
;
	typedef struct packed {
		logic [11:0] wa;
		logic [11:0] ra;
		logic [7:0]  d;
		logic [31:0] e;
	} art_row_type;

	logic              pclk, presetn, psel, penable, pwrite, event_input;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd, hold;
	logic              pready, pslverr, timer_out, pwm_clock, irq, err, lvl;
	logic [1:0]        irq_priority;
	logic [15:0]       irq_vector;
	int                err_count, samples_checked, cyc, last, period, pulses;
	art_row_type       rows [0:6] = '{
		'{ADDR_COUNT, ADDR_RELOAD, 8'h5a, 32'h5a},     // counter write copies
		'{ADDR_COUNT, ADDR_COUNT, 8'hc3, 32'hc3},
		'{ADDR_RELOAD, ADDR_RELOAD, 8'h33, 32'h33},
		'{ADDR_CONTROL, ADDR_CONTROL, 8'h07, 32'h77},  // fixed ones
		'{ADDR_CONTROL, ADDR_CONTROL, 8'h80, 32'hf0},
		'{ADDR_MASK, ADDR_MASK, 8'h01, 32'h01},
		'{12'h018, 12'h018, 8'hff, 32'h00}};           // unmapped

	// 100 mhz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	art_timer uut (
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.event_input  (event_input),
		.timer_out    (timer_out),
		.pwm_clock    (pwm_clock),
		.irq          (irq),
		.irq_priority (irq_priority),
		.irq_vector   (irq_vector)
	);

	art_event_src src (
		.pclk        (pclk),
		.event_input (event_input),
		.timer_out   (timer_out)
	);

	// spacing and number of overflow pulses
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (pwm_clock === 1'b1) begin
			period <= cyc - last;
			last <= cyc;
			pulses <= pulses + 1;
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one apb transfer, then one idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_pulses(input int n);
		int t;
		t = pulses + n;
		while (pulses < t) @(posedge pclk);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// watchdog against a hung wait
	initial begin
		#100000;
		err_count++;
		complete_run();
	end

	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{err_count, samples_checked, cyc, last, period, pulses} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk("control reset", 32'h70, rd);
		chk("out reset", 32'h0, timer_out);
		chk("ready", 32'h1, pready);
		chk("vector", 32'h72, irq_vector);
		$display("reset test done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].wa, rows[i].d);
			apb(1'b0, rows[i].ra, 32'h0);
			chk("row read", rows[i].e, rd);
		end
		chk("unmapped error", 32'h1, err);
		chk("out level", 32'h1, timer_out);
		chk("pin load", 32'h1, src.load_level);
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, ADDR_PRIORITY, p);
			chk("priority", (p == 0) ? 0 : ((p > 1) ? 2 : 1), irq_priority);
		end
		$display("table test done");
		// count and reload at ffh overflow on every tick
		for (int s = 0; s < 7; s++) begin
			apb(1'b1, ADDR_COUNT, 32'hff);
			apb(1'b1, ADDR_CONTROL, 32'h08 | s);
			wait_pulses(3);
			chk("tick period", 1 << s, period);
		end
		apb(1'b1, ADDR_COUNT, 32'hfe);
		apb(1'b1, ADDR_RELOAD, 32'h55);
		apb(1'b1, ADDR_CONTROL, 32'h09);
		wait_pulses(3);
		chk("reload period", 32'd342, period);
		lvl = timer_out;
		wait_pulses(1);
		chk("toggle", {31'h0, ~lvl}, timer_out);
		// halt well clear of the next overflow
		apb(1'b1, ADDR_CONTROL, {24'h0, timer_out, 7'h00});
		apb(1'b0, ADDR_COUNT, 32'h0);
		hold = rd;
		repeat (20) @(posedge pclk);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk("halted count", hold, rd);
		$display("count test done");
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("flag", 32'h1, rd);
		chk("irq enabled", 32'h1, irq);
		apb(1'b1, ADDR_MASK, 32'h0);
		chk("irq masked", 32'h0, irq);
		apb(1'b1, ADDR_MASK, 32'h1);
		apb(1'b1, ADDR_STATUS, 32'h1);
		chk("irq cleared", 32'h0, irq);
		$display("interrupt test done");
		// event input as count clock
		apb(1'b1, ADDR_COUNT, 32'hfd);
		apb(1'b1, ADDR_CONTROL, 32'h0f);
		src.pulse(3);
		src.pulse(3);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk("event count", 32'hff, rd);
		src.pulse(3);
		chk("event irq", 32'h1, irq);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk("event reload", 32'hfd, rd);
		$display("event test done");
		// reset while running
		apb(1'b1, ADDR_CONTROL, 32'h88);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk("control rereset", 32'h70, rd);
		chk("out rereset", 32'h0, timer_out);
		chk("irq rereset", 32'h0, irq);
		$display("reset rerun test done");
		complete_run();
	end
endmodule
